//--- vpt_cfg.svh
// Notes on behaviour
// - The network identifier is a 12-bit tag field, allowing 4094 usable networks.
// - Identifiers 0 and 4095 are reserved and never given to a network.
// - After reset every port is a member of default network 1.
// - Priority comes from a 3-bit tag field; 0 lowest, 7 highest.
// - Frames arriving without a tag get priority 0.
// - Tagged and untagged frames may arrive mixed on one port.
// - Tagging inserts a field holding identifier and priority, lengthening the frame.
// - A classified frame leaves only through member ports of its network.
// - Toward a non-tagging member port the tag is removed again.
// - The membership table holds up to 32 entries of identifier plus member ports.
// - Membership entries accept identifiers 1 to 4094 only.
// - Wired, wireless station and point-to-point ports all count as members when listed.
// - Each port has transmit tagging, untagged acceptance, accept-any and default identifier.
// - Transmit tagging affects only frames sent, never received handling.
// - Untagged received frames pass only when untagged acceptance is on.
// - With accept-any on, tagged frames of any identifier other than 0 and 4095 are accepted.
// - Untagged received frames are classified to the port default identifier.
// - Frames of the port default identifier leave untagged even with tagging on.
// - Tags use the configurable protocol type, reset value 8100 hex.
`ifndef VPT_CFG_SVH
`define VPT_CFG_SVH

`define VPT_NPORT          9
`define VPT_NNET           32
`define VPT_VID_W          12
`define VPT_PCP_W          3
`define VPT_VID_RSV_LO     12'h000
`define VPT_VID_RSV_HI     12'hfff
`define VPT_VID_DEFAULT    12'h001
`define VPT_TPID_RESET     16'h8100
`define VPT_ADDR_BYTES     4'hc
`define VPT_TAG_BYTES      4'h4
`define VPT_TYPE_BYTES     4'h2
`define VPT_FIFO_DEPTH     4
`define VPT_FIFO_WIDTH     9
// Port layout: 0 wired, 1..2 wireless station, 3..8 point-to-point
`define VPT_WIRED_PORT     0
`define VPT_WLAN_FIRST     1
`define VPT_P2P_FIRST      3
`define VPT_ALL_PORTS      9'h1ff
`define VPT_RST_USE_TAG    9'h000
`define VPT_RST_UNTAGGED   9'h1ff
`define VPT_RST_ANY_NET    9'h1ff

`endif

//--- vpt_fifo.sv
`timescale 1ns/100ps
`include "vpt_cfg.svh"
module vpt_fifo #(
    parameter int WIDTH = `VPT_FIFO_WIDTH,
    parameter int DEPTH = `VPT_FIFO_DEPTH
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    input  wire logic [WIDTH-1:0] wr_data_i,
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i,
    output logic [WIDTH-1:0]      rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q, wr_ptr_d;
    logic [AW:0]      rd_ptr_q, rd_ptr_d;
    logic             full, empty, do_wr, do_rd;

    assign full       = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign empty      = (wr_ptr_q == rd_ptr_q);
    assign wr_ready_o = !full;
    assign rd_valid_o = !empty;
    assign rd_data_o  = mem_q[rd_ptr_q[AW-1:0]];
    assign do_wr      = wr_valid_i && !full;
    assign do_rd      = rd_ready_i && !empty;

    always_comb begin
        wr_ptr_d = wr_ptr_q + (AW+1)'(do_wr);
        rd_ptr_d = rd_ptr_q + (AW+1)'(do_rd);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (do_wr) begin
            mem_q[wr_ptr_q[AW-1:0]] <= wr_data_i;
        end
    end
endmodule // vpt_fifo

//--- vpt_pkg.sv
`include "vpt_cfg.svh"
package vpt_pkg;
    typedef logic [`VPT_VID_W-1:0] vpt_vid_t;
    typedef logic [`VPT_NPORT-1:0] vpt_pmask_t;
    typedef logic [3:0]            vpt_port_t;

    typedef enum logic [3:0] {
        VPT_IDLE, VPT_ADDR, VPT_TYPE, VPT_TCI, VPT_DECIDE, VPT_DROP,
        VPT_EMIT_ADDR, VPT_EMIT_TAG, VPT_EMIT_TYPE, VPT_BODY
    } vpt_state_e;

    // An identifier may name a network unless it is one of the two reserved codes
    function automatic logic vpt_vid_usable(input vpt_vid_t vid);
        return (vid != `VPT_VID_RSV_LO) && (vid != `VPT_VID_RSV_HI);
    endfunction
endpackage

//--- vpt_sink_model.sv
`timescale 1ns/100ps
module vpt_sink_model (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_eof_i,
    input  wire logic       slow_i,
    output logic            tx_ready_o
);
    logic [7:0] q[$];
    int         n_eof = 0;
    logic [2:0] gap_q;

    // Slow mode takes one byte in eight, so the FIFO fills and rx stalls
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_q <= 3'h0;
            tx_ready_o <= 1'b0;
        end else begin
            if (tx_valid_i && tx_ready_o) begin
                q.push_back(tx_data_i);
                if (tx_eof_i) n_eof++;
            end
            gap_q <= gap_q + 3'h1;
            tx_ready_o <= !slow_i || (gap_q == 3'h6);
        end
    end
endmodule // vpt_sink_model

//--- vpt_tagger.sv
`timescale 1ns/100ps
`include "vpt_cfg.svh"
module vpt_tagger
    import vpt_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        rx_valid_i,
    output logic             rx_ready_o,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_sof_i,
    input  wire logic        rx_eof_i,
    input  wire vpt_port_t   rx_port_i,
    input  wire vpt_port_t   tx_port_i,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    output logic [7:0]       tx_data_o,
    output logic             tx_eof_o,
    output vpt_vid_t         frame_vid_o,
    output logic [2:0]       frame_pcp_o,
    output logic             frame_tagged_o,
    output logic             frame_drop_o,
    input  wire logic        net_wr_i,
    input  wire logic [4:0]  net_idx_i,
    input  wire vpt_vid_t    net_vid_i,
    input  wire vpt_pmask_t  net_members_i,
    output logic             net_wr_err_o,
    input  wire logic        port_wr_i,
    input  wire vpt_port_t   port_idx_i,
    input  wire logic        port_use_tag_i,
    input  wire logic        port_allow_untagged_i,
    input  wire logic        port_accept_any_network_i,
    input  wire vpt_vid_t    port_default_net_id_i,
    input  wire logic        tpid_wr_i,
    input  wire logic [15:0] tpid_i
);
    // ------------------------------------------------------------------
    // Configuration tables
    // ------------------------------------------------------------------
    vpt_vid_t    net_vid_q [`VPT_NNET];
    vpt_vid_t    net_vid_d [`VPT_NNET];
    vpt_pmask_t  net_mem_q [`VPT_NNET];
    vpt_pmask_t  net_mem_d [`VPT_NNET];
    vpt_pmask_t  use_tag_q, use_tag_d, untag_ok_q, untag_ok_d, any_net_q, any_net_d;
    vpt_vid_t    pdef_q [`VPT_NPORT];
    vpt_vid_t    pdef_d [`VPT_NPORT];
    logic [15:0] tpid_q, tpid_d;
    logic        wr_err_q, wr_err_d;

    always_comb begin
        net_vid_d  = net_vid_q;
        net_mem_d  = net_mem_q;
        use_tag_d  = use_tag_q;
        untag_ok_d = untag_ok_q;
        any_net_d  = any_net_q;
        pdef_d     = pdef_q;
        tpid_d     = tpid_wr_i ? tpid_i : tpid_q;
        wr_err_d   = 1'b0;
        if (net_wr_i) begin
            if (vpt_vid_usable(net_vid_i)) begin
                net_vid_d[net_idx_i] = net_vid_i;
                net_mem_d[net_idx_i] = net_members_i;
            end else begin
                wr_err_d = 1'b1;
            end
        end
        if (port_wr_i) begin
            if (port_idx_i < 4'(`VPT_NPORT) && vpt_vid_usable(port_default_net_id_i)) begin
                use_tag_d[port_idx_i]  = port_use_tag_i;
                untag_ok_d[port_idx_i] = port_allow_untagged_i;
                any_net_d[port_idx_i]  = port_accept_any_network_i;
                pdef_d[port_idx_i]     = port_default_net_id_i;
            end else begin
                wr_err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < `VPT_NNET; i++) begin
                net_vid_q[i] <= (i == 0) ? `VPT_VID_DEFAULT : `VPT_VID_RSV_LO;
                net_mem_q[i] <= (i == 0) ? `VPT_ALL_PORTS : '0;
            end
            for (int i = 0; i < `VPT_NPORT; i++) begin
                pdef_q[i] <= `VPT_VID_DEFAULT;
            end
            use_tag_q  <= `VPT_RST_USE_TAG;
            untag_ok_q <= `VPT_RST_UNTAGGED;
            any_net_q  <= `VPT_RST_ANY_NET;
            tpid_q     <= `VPT_TPID_RESET;
            wr_err_q   <= 1'b0;
        end else begin
            net_vid_q  <= net_vid_d;
            net_mem_q  <= net_mem_d;
            pdef_q     <= pdef_d;
            use_tag_q  <= use_tag_d;
            untag_ok_q <= untag_ok_d;
            any_net_q  <= any_net_d;
            tpid_q     <= tpid_d;
            wr_err_q   <= wr_err_d;
        end
    end
    assign net_wr_err_o = wr_err_q;

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    vpt_state_e  st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [95:0] hdr_q, hdr_d;
    logic [15:0] typ_q, typ_d, tci_q, tci_d;
    logic        tagged_q, tagged_d, otag_q, otag_d, drop_q, drop_d;
    vpt_port_t   rxp_q, rxp_d, dstp_q, dstp_d;
    vpt_vid_t    vid_q, vid_d;
    logic [2:0]  pcp_q, pcp_d;
    logic        fw_valid, fw_ready, fw_eof;
    logic [7:0]  fw_data;
    logic        rx_hs;

    // ------------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------------
    vpt_vid_t    cls_vid;
    logic [2:0]  cls_pcp;
    vpt_pmask_t  cls_mem;
    logic        ports_ok, cls_accept, cls_fwd, cls_otag;

    always_comb begin
        cls_vid = tagged_q ? tci_q[11:0] : pdef_q[rxp_q];
        cls_pcp = tagged_q ? tci_q[15:13] : 3'h0;
        cls_mem = '0;
        for (int i = 0; i < `VPT_NNET; i++) begin
            if (vpt_vid_usable(net_vid_q[i]) && net_vid_q[i] == cls_vid) begin
                cls_mem = cls_mem | net_mem_q[i];
            end
        end
        ports_ok   = (rxp_q < 4'(`VPT_NPORT)) && (dstp_q < 4'(`VPT_NPORT));
        // Receive checks never look at the transmit tagging option
        cls_accept = ports_ok && (tagged_q
                   ? (vpt_vid_usable(cls_vid) && (any_net_q[rxp_q] || cls_mem[rxp_q]))
                   : untag_ok_q[rxp_q]);
        cls_fwd    = ports_ok && cls_mem[dstp_q];
        cls_otag   = ports_ok && use_tag_q[dstp_q] && (cls_vid != pdef_q[dstp_q]);
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    assign rx_hs = rx_valid_i && rx_ready_o;

    always_comb begin
        st_d = st_q;   cnt_d = cnt_q;   hdr_d = hdr_q;   typ_d = typ_q;
        tci_d = tci_q; tagged_d = tagged_q; otag_d = otag_q; rxp_d = rxp_q;
        dstp_d = dstp_q; vid_d = vid_q; pcp_d = pcp_q; drop_d = 1'b0;
        rx_ready_o = 1'b0;
        fw_valid   = 1'b0;
        fw_data    = 8'h00;
        fw_eof     = 1'b0;
        case (st_q)
            VPT_IDLE: begin
                rx_ready_o = 1'b1;
                if (rx_hs && rx_sof_i && !rx_eof_i) begin
                    hdr_d  = {hdr_q[87:0], rx_data_i};
                    cnt_d  = 4'h1;
                    rxp_d  = rx_port_i;
                    dstp_d = tx_port_i;
                    st_d   = VPT_ADDR;
                end
            end
            VPT_ADDR: begin
                rx_ready_o = 1'b1;
                if (rx_hs) begin
                    hdr_d = {hdr_q[87:0], rx_data_i};
                    cnt_d = cnt_q + 4'h1;
                    if (rx_eof_i) begin
                        drop_d = 1'b1;
                        st_d   = VPT_IDLE;
                    end else if (cnt_q == `VPT_ADDR_BYTES - 4'h1) begin
                        cnt_d = 4'h0;
                        st_d  = VPT_TYPE;
                    end
                end
            end
            VPT_TYPE, VPT_TCI: begin
                rx_ready_o = 1'b1;
                if (rx_hs) begin
                    cnt_d = cnt_q + 4'h1;
                    if (st_q == VPT_TYPE) typ_d = {typ_q[7:0], rx_data_i};
                    else tci_d = {tci_q[7:0], rx_data_i};
                    if (rx_eof_i) begin
                        drop_d = 1'b1;
                        st_d   = VPT_IDLE;
                    end else if (cnt_q == 4'h1) begin
                        cnt_d = 4'h0;
                        // Tagged and plain frames share one path; the type decides
                        if (st_q == VPT_TYPE) begin
                            tagged_d = ({typ_q[7:0], rx_data_i} == tpid_q);
                            st_d     = tagged_d ? VPT_TCI : VPT_DECIDE;
                        end else begin
                            st_d = VPT_DECIDE;
                        end
                    end
                end
            end
            VPT_DECIDE: begin
                vid_d  = cls_vid;
                pcp_d  = cls_pcp;
                otag_d = cls_otag;
                cnt_d  = 4'h0;
                if (cls_accept && cls_fwd) begin
                    st_d = VPT_EMIT_ADDR;
                end else begin
                    drop_d = 1'b1;
                    st_d   = VPT_DROP;
                end
            end
            VPT_DROP: begin
                rx_ready_o = 1'b1;
                if (rx_hs && rx_eof_i) st_d = VPT_IDLE;
            end
            VPT_EMIT_ADDR: begin
                fw_valid = 1'b1;
                fw_data  = hdr_q[95:88];
                if (fw_ready) begin
                    hdr_d = {hdr_q[87:0], 8'h00};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `VPT_ADDR_BYTES - 4'h1) begin
                        cnt_d = 4'h0;
                        // A received tag not wanted on egress is simply not re-sent
                        st_d  = otag_q ? VPT_EMIT_TAG
                              : (tagged_q ? VPT_BODY : VPT_EMIT_TYPE);
                    end
                end
            end
            VPT_EMIT_TAG: begin
                fw_valid = 1'b1;
                case (cnt_q[1:0])
                    2'h0:    fw_data = tpid_q[15:8];
                    2'h1:    fw_data = tpid_q[7:0];
                    2'h2:    fw_data = {pcp_q, 1'b0, vid_q[11:8]};
                    default: fw_data = vid_q[7:0];
                endcase
                if (fw_ready) begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `VPT_TAG_BYTES - 4'h1) begin
                        cnt_d = 4'h0;
                        st_d  = tagged_q ? VPT_BODY : VPT_EMIT_TYPE;
                    end
                end
            end
            VPT_EMIT_TYPE: begin
                fw_valid = 1'b1;
                fw_data  = (cnt_q == 4'h0) ? typ_q[15:8] : typ_q[7:0];
                if (fw_ready) begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `VPT_TYPE_BYTES - 4'h1) st_d = VPT_BODY;
                end
            end
            VPT_BODY: begin
                fw_valid   = rx_valid_i;
                rx_ready_o = fw_ready;
                fw_data    = rx_data_i;
                fw_eof     = rx_eof_i;
                if (rx_hs && rx_eof_i) st_d = VPT_IDLE;
            end
            default: st_d = VPT_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= VPT_IDLE;  cnt_q <= 4'h0;  hdr_q <= '0;  typ_q <= 16'h0000;
            tci_q <= 16'h0000; tagged_q <= 1'b0; otag_q <= 1'b0; drop_q <= 1'b0;
            rxp_q <= 4'h0;     dstp_q <= 4'h0;  vid_q <= `VPT_VID_DEFAULT; pcp_q <= 3'h0;
        end else begin
            st_q <= st_d;      cnt_q <= cnt_d;  hdr_q <= hdr_d;  typ_q <= typ_d;
            tci_q <= tci_d;    tagged_q <= tagged_d; otag_q <= otag_d; drop_q <= drop_d;
            rxp_q <= rxp_d;    dstp_q <= dstp_d; vid_q <= vid_d; pcp_q <= pcp_d;
        end
    end

    assign frame_vid_o    = vid_q;
    assign frame_pcp_o    = pcp_q;
    assign frame_tagged_o = otag_q;
    assign frame_drop_o   = drop_q;

    // ------------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------------
    vpt_fifo #(
        .WIDTH(`VPT_FIFO_WIDTH),
        .DEPTH(`VPT_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .wr_valid_i(fw_valid),
        .wr_ready_o(fw_ready),
        .wr_data_i ({fw_eof, fw_data}),
        .rd_valid_o(tx_valid_o),
        .rd_ready_i(tx_ready_i),
        .rd_data_o ({tx_eof_o, tx_data_o})
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_decide_untagged;
        st_q == VPT_DECIDE && !tagged_q;
    endsequence
    sequence s_decide_tagged;
        st_q == VPT_DECIDE && tagged_q;
    endsequence

    a_untagged_refused:
        assert property (s_decide_untagged and !untag_ok_q[rxp_q] |=> st_q == VPT_DROP && drop_q)
        else $error("untagged frame not dropped");
    a_foreign_refused:
        assert property (s_decide_tagged and !any_net_q[rxp_q] && !cls_mem[rxp_q]
                         |=> st_q == VPT_DROP)
        else $error("foreign network frame not dropped");
    a_any_network_pass:
        assert property (s_decide_tagged and any_net_q[rxp_q] && cls_fwd
                         && vpt_vid_usable(tci_q[11:0]) |=> st_q == VPT_EMIT_ADDR)
        else $error("accept-any frame refused");
    a_nonmember_egress:
        assert property (st_q == VPT_DECIDE && !cls_mem[dstp_q] |=> st_q == VPT_DROP)
        else $error("frame sent to non-member port");
    a_untagged_class:
        assert property (s_decide_untagged |=> frame_pcp_o == 3'h0
                         && frame_vid_o == pdef_q[rxp_q])
        else $error("untagged classification wrong");
    a_native_untagged:
        assert property (st_q == VPT_DECIDE && cls_vid == pdef_q[dstp_q] |=> !frame_tagged_o)
        else $error("default network frame tagged");
    a_tag_insert:
        assert property (st_q == VPT_EMIT_TAG && cnt_q == 4'h0 && fw_ready
                         |-> fw_data == tpid_q[15:8] ##1 fw_data == tpid_q[7:0])
        else $error("tag protocol type not emitted");
    a_tag_strip:
        assert property (st_q == VPT_EMIT_ADDR && cnt_q == 4'hb && fw_ready && tagged_q
                         && !otag_q |=> st_q == VPT_BODY)
        else $error("tag not removed");
    a_reserved_write:
        assert property (net_wr_i && !vpt_vid_usable(net_vid_i)
                         |=> net_wr_err_o
                         && net_vid_q[$past(net_idx_i)] == $past(net_vid_q[net_idx_i]))
        else $error("reserved identifier accepted");
endmodule // vpt_tagger

//--- vpt_tagger_tb.sv
`timescale 1ns/100ps
module vpt_tagger_tb;
    import vpt_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk_sys_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       rx_valid_i = 1'b0, rx_sof_i = 1'b0, rx_eof_i = 1'b0;
    logic       tx_ready_i, slow = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    vpt_port_t  rx_port_i = 4'h0, tx_port_i = 4'h0, port_idx_i = 4'h0;
    logic       net_wr_i = 1'b0, port_wr_i = 1'b0, tpid_wr_i = 1'b0;
    logic       port_use_tag_i = 1'b0, port_allow_untagged_i = 1'b1;
    logic       port_accept_any_network_i = 1'b1;
    logic [4:0] net_idx_i = 5'h00;
    vpt_vid_t   net_vid_i = 12'h001, port_default_net_id_i = 12'h001;
    vpt_pmask_t net_members_i = 9'h000;
    logic [15:0] tpid_i = 16'h8100;
    logic       rx_ready_o, tx_valid_o, tx_eof_o, frame_tagged_o, frame_drop_o, net_wr_err_o;
    logic [7:0] tx_data_o;
    vpt_vid_t   frame_vid_o;
    logic [2:0] frame_pcp_o;
    logic [7:0] fr[$], ex[$];
    int         n_mismatch = 0, n_tests = 0, n_drop = 0, n_err = 0;

    always #50 clk_sys_i = ~clk_sys_i;

    vpt_tagger dut (.clk_sys_i, .reset_n_i, .rx_valid_i, .rx_ready_o, .rx_data_i, .rx_sof_i,
        .rx_eof_i, .rx_port_i, .tx_port_i, .tx_valid_o, .tx_ready_i, .tx_data_o, .tx_eof_o,
        .frame_vid_o, .frame_pcp_o, .frame_tagged_o, .frame_drop_o, .net_wr_i, .net_idx_i,
        .net_vid_i, .net_members_i, .net_wr_err_o, .port_wr_i, .port_idx_i, .port_use_tag_i,
        .port_allow_untagged_i, .port_accept_any_network_i, .port_default_net_id_i,
        .tpid_wr_i, .tpid_i);
    vpt_sink_model sink (.clk_sys_i, .reset_n_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_eof_i(tx_eof_o), .slow_i(slow), .tx_ready_o(tx_ready_i));

    always @(posedge clk_sys_i) begin
        if (frame_drop_o === 1'b1) n_drop++;
        if (net_wr_err_o === 1'b1) n_err++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr_net(input logic [4:0] i, input vpt_vid_t v, input vpt_pmask_t m);
        @(posedge clk_sys_i);
        net_wr_i <= 1'b1;
        net_idx_i <= i;
        net_vid_i <= v;
        net_members_i <= m;
        @(posedge clk_sys_i);
        net_wr_i <= 1'b0;
    endtask

    task automatic wr_port(input vpt_port_t i, input logic t, u, a, input vpt_vid_t d);
        @(posedge clk_sys_i);
        port_wr_i <= 1'b1;
        port_idx_i <= i;
        port_use_tag_i <= t;
        port_allow_untagged_i <= u;
        port_accept_any_network_i <= a;
        port_default_net_id_i <= d;
        @(posedge clk_sys_i);
        port_wr_i <= 1'b0;
    endtask

    // Frame of 12 address bytes, optional tag, 8 more bytes; ex is the wanted copy
    task automatic build(input bit ti, to, input logic [2:0] p, input vpt_vid_t v);
        logic [7:0] tg[4];
        tg = '{8'h81, 8'h00, {p, 1'b0, v[11:8]}, v[7:0]};
        fr.delete();
        ex.delete();
        for (int i = 0; i < 20; i++) begin
            if (i == 12) foreach (tg[j]) begin
                if (ti) fr.push_back(tg[j]);
                if (to) ex.push_back(tg[j]);
            end
            fr.push_back(8'(i + 16));
            ex.push_back(8'(i + 16));
        end
    endtask

    task automatic run(input vpt_port_t s, d, input bit drp);
        int e0, d0, k;
        e0 = sink.n_eof;
        d0 = n_drop;
        sink.q.delete();
        for (int i = 0; i < fr.size(); i++) begin
            if (i == 0) @(posedge clk_sys_i);
            rx_valid_i <= 1'b1;
            rx_data_i <= fr[i];
            rx_sof_i <= (i == 0);
            rx_eof_i <= (i == fr.size() - 1);
            rx_port_i <= s;
            tx_port_i <= d;
            @(negedge clk_sys_i);
            while (rx_ready_o !== 1'b1) @(negedge clk_sys_i);
            @(posedge clk_sys_i);
        end
        rx_valid_i <= 1'b0;
        for (k = 0; k < 400 && sink.n_eof == e0 && n_drop == d0; k++) @(posedge clk_sys_i);
        if (k == 400) n_mismatch++;
        chk("drop", n_drop - d0, drp);
        if (!drp) begin
            chk("len", sink.q.size(), ex.size());
            foreach (ex[i]) chk("byte", sink.q[i], ex[i]);
        end
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        chk("vid", frame_vid_o, 12'h001);
        chk("txv", tx_valid_o, 1'b0);
        build(0, 0, 3'h0, 12'h001);
        run(4'h0, 4'h1, 0);
        chk("pcp", frame_pcp_o, 3'h0);
        wr_net(5'h01, 12'h005, 9'h007);
        wr_net(5'h1f, 12'hffe, 9'h002);
        wr_port(4'h1, 1'b1, 1'b1, 1'b1, 12'h001);
        slow <= 1'b1;
        build(1, 1, 3'h5, 12'h005);
        run(4'h0, 4'h1, 0);
        chk("pcp", frame_pcp_o, 3'h5);
        chk("tag", frame_tagged_o, 1'b1);
        build(1, 1, 3'h7, 12'hffe);
        run(4'h0, 4'h1, 0);
        chk("vid", frame_vid_o, 12'hffe);
        slow <= 1'b0;
        build(0, 0, 3'h0, 12'h001);
        run(4'h0, 4'h1, 0);
        build(1, 0, 3'h2, 12'h005);
        run(4'h0, 4'h2, 0);
        run(4'h0, 4'h4, 1);
        wr_net(5'h02, 12'h000, 9'h1ff);
        wr_net(5'h02, 12'hfff, 9'h1ff);
        wr_port(4'h9, 1'b0, 1'b1, 1'b1, 12'h001);
        wr_port(4'h2, 1'b0, 1'b1, 1'b1, 12'hfff);
        repeat (3) @(posedge clk_sys_i);
        chk("err", n_err, 4);
        wr_port(4'h0, 1'b0, 1'b0, 1'b0, 12'h001);
        build(1, 1, 3'h1, 12'hffe);
        run(4'h0, 4'h1, 1);
        build(0, 0, 3'h0, 12'h001);
        run(4'h0, 4'h1, 1);
        build(1, 1, 3'h1, 12'h005);
        run(4'h0, 4'h1, 0);
        @(posedge clk_sys_i);
        tpid_i <= 16'h9100;
        tpid_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        tpid_wr_i <= 1'b0;
        build(1, 1, 3'h3, 12'h005);
        fr[12] = 8'h91;
        ex[12] = 8'h91;
        run(4'h1, 4'h1, 0);
        chk("tag", frame_tagged_o, 1'b1);
        wrap_up;
    end
endmodule // vpt_tagger_tb
